// file: rtl/lcm_load_current_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "lcm_map.vh"

module lcm_load_current_regs
#(
  parameter integer MEAS_CYCLES = `LCM_MEAS_CYCLES,
  parameter [6:0]   DEV_ADDR    = `LCM_DEV_ADDR
)
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        phase2_limit_in,
  input  wire        phase3_limit_in,
  input  wire        meas_ready_mask,
  input  wire [39:0] phase_current_code,
  input  wire [3:0]  phase_is_master,
  input  wire [7:0]  phase_leader,
  output wire        phase2_overcurrent_raw,
  output wire        phase3_overcurrent_raw,
  output wire        phase2_overcurrent_irq,
  output wire        phase3_overcurrent_irq,
  output reg         meas_ready_irq,
  output wire        meas_busy
);

  // serial engine states, one-hot
  localparam [8:0] ST_IDLE  = 9'h001;
  localparam [8:0] ST_ADDR  = 9'h002;
  localparam [8:0] ST_ACKA  = 9'h004;
  localparam [8:0] ST_REG   = 9'h008;
  localparam [8:0] ST_ACKR  = 9'h010;
  localparam [8:0] ST_WDATA = 9'h020;
  localparam [8:0] ST_ACKW  = 9'h040;
  localparam [8:0] ST_RDATA = 9'h080;
  localparam [8:0] ST_RACK  = 9'h100;

  reg  [8:0]  state_reg;
  reg  [2:0]  bit_cnt_reg;
  reg         got_byte_reg;
  reg  [7:0]  shift_reg;
  reg         rw_reg;
  reg  [7:0]  ptr_reg;
  reg         scl_prev_reg;
  reg         sda_prev_reg;
  reg         wr_stb_reg;
  reg  [7:0]  wr_addr_reg;
  reg  [7:0]  wr_data_reg;

  reg  [7:0]  mask_reg;
  reg  [7:0]  sel_reg;
  reg         meas_start_reg;
  reg  [7:0]  rd_data;

  wire [9:0]  result;
  wire        meas_done;
  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;

  // pin edges, pins taken as synchronous to clk
  assign scl_rise  = scl_in & ~scl_prev_reg;
  assign scl_fall  = ~scl_in & scl_prev_reg;
  assign bus_start = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  assign bus_stop  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;

  // read mux over the register map
  always @*
  begin
    if (ptr_reg == `LCM_OFS_MASK)
      rd_data = mask_reg;
    else if (ptr_reg == `LCM_OFS_SEL)
      rd_data = sel_reg;
    else if (ptr_reg == `LCM_OFS_RES_HI)
      rd_data = {6'h00, result[`LCM_RES_HI_MSB:`LCM_RES_HI_LSB]};
    else if (ptr_reg == `LCM_OFS_RES_LO)
      rd_data = result[`LCM_RES_LO_MSB:`LCM_RES_LO_LSB];
    else
      rd_data = `LCM_RD_UNMAPPED;
  end

  // pin history for edge and start/stop detection
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else if (ce)
    begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
    end
  end

  // serial slave: address, pointer, write data, read data with auto-increment
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      got_byte_reg <= 1'b0;
      shift_reg    <= 8'h00;
      rw_reg       <= 1'b0;
      ptr_reg      <= 8'h00;
      sda_out      <= 1'b0;
      sda_oe       <= 1'b0;
      wr_stb_reg   <= 1'b0;
      wr_addr_reg  <= 8'h00;
      wr_data_reg  <= 8'h00;
    end
    else if (ce)
    begin
      wr_stb_reg <= 1'b0;
      sda_out    <= 1'b0;
      if (bus_start)
      begin
        state_reg    <= ST_ADDR;
        bit_cnt_reg  <= 3'h0;
        got_byte_reg <= 1'b0;
        sda_oe       <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state_reg)
          ST_ADDR, ST_REG, ST_WDATA:
          begin
            shift_reg   <= {shift_reg[6:0], sda_in};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
              got_byte_reg <= 1'b1;
          end
          ST_RDATA:
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
              got_byte_reg <= 1'b1;
          end
          ST_RACK:
          begin
            // master not acknowledging ends the read
            if (sda_in)
              state_reg <= ST_IDLE;
          end
          default:
          begin
            bit_cnt_reg <= bit_cnt_reg;
          end
        endcase
      end
      else if (scl_fall)
      begin
        case (state_reg)
          ST_ADDR:
          begin
            if (got_byte_reg)
            begin
              got_byte_reg <= 1'b0;
              if (shift_reg[7:1] == DEV_ADDR)
              begin
                rw_reg    <= shift_reg[0];
                sda_oe    <= 1'b1;
                state_reg <= ST_ACKA;
              end
              else
                state_reg <= ST_IDLE;
            end
          end
          ST_ACKA:
          begin
            bit_cnt_reg <= 3'h0;
            if (rw_reg)
            begin
              shift_reg <= rd_data;
              sda_oe    <= ~rd_data[7];
              state_reg <= ST_RDATA;
            end
            else
            begin
              sda_oe    <= 1'b0;
              state_reg <= ST_REG;
            end
          end
          ST_REG:
          begin
            if (got_byte_reg)
            begin
              got_byte_reg <= 1'b0;
              ptr_reg      <= shift_reg;
              sda_oe       <= 1'b1;
              state_reg    <= ST_ACKR;
            end
          end
          ST_ACKR:
          begin
            sda_oe      <= 1'b0;
            bit_cnt_reg <= 3'h0;
            state_reg   <= ST_WDATA;
          end
          ST_WDATA:
          begin
            if (got_byte_reg)
            begin
              got_byte_reg <= 1'b0;
              wr_stb_reg   <= 1'b1;
              wr_addr_reg  <= ptr_reg;
              wr_data_reg  <= shift_reg;
              sda_oe       <= 1'b1;
              state_reg    <= ST_ACKW;
            end
          end
          ST_ACKW:
          begin
            sda_oe      <= 1'b0;
            bit_cnt_reg <= 3'h0;
            ptr_reg     <= ptr_reg + 8'h01;
            state_reg   <= ST_WDATA;
          end
          ST_RDATA:
          begin
            if (got_byte_reg)
            begin
              got_byte_reg <= 1'b0;
              sda_oe       <= 1'b0;
              ptr_reg      <= ptr_reg + 8'h01;
              state_reg    <= ST_RACK;
            end
            else
            begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe    <= ~shift_reg[6];
            end
          end
          ST_RACK:
          begin
            bit_cnt_reg <= 3'h0;
            shift_reg   <= rd_data;
            sda_oe      <= ~rd_data[7];
            state_reg   <= ST_RDATA;
          end
          default:
          begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // writable registers; reserved bits are stored, result is read-only
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_reg       <= `LCM_MASK_RESET;  // both masks set
      sel_reg        <= `LCM_SEL_RESET;
      meas_start_reg <= 1'b0;
    end
    else if (ce)
    begin
      meas_start_reg <= 1'b0;
      if (wr_stb_reg)
      begin
        if (wr_addr_reg == `LCM_OFS_MASK)
          mask_reg <= wr_data_reg;
        else if (wr_addr_reg == `LCM_OFS_SEL)
        begin
          sel_reg        <= wr_data_reg;
          meas_start_reg <= 1'b1;         // even if unchanged
        end
      end
    end
  end

  // ready event gated by its own mask
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      meas_ready_irq <= 1'b0;
    else if (ce)
      meas_ready_irq <= meas_done & ~meas_ready_mask;
  end

  // phase-two overcurrent raw bit and event
  lcm_limit_event u_phase2
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .limit_in (phase2_limit_in),
    .mask     (mask_reg[`LCM_P2_MASK_BIT]),
    .raw_reg  (phase2_overcurrent_raw),
    .irq_reg  (phase2_overcurrent_irq)
  );

  // phase-three overcurrent raw bit and event
  lcm_limit_event u_phase3
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .limit_in (phase3_limit_in),
    .mask     (mask_reg[`LCM_P3_MASK_BIT]),
    .raw_reg  (phase3_overcurrent_raw),
    .irq_reg  (phase3_overcurrent_irq)
  );

  // measurement, code already at 20 mA per step
  lcm_meas_engine #(.MEAS_CYCLES(MEAS_CYCLES)) u_meas
  (
    .clk                (clk),
    .rst_n              (rst_n),
    .ce                 (ce),
    .start              (meas_start_reg),
    .phase              (sel_reg[`LCM_SEL_MSB:`LCM_SEL_LSB]),
    .phase_current_code (phase_current_code),
    .phase_is_master    (phase_is_master),
    .phase_leader       (phase_leader),
    .result_reg         (result),
    .done_reg           (meas_done),
    .busy_reg           (meas_busy)
  );

endmodule // lcm_load_current_regs
`default_nettype wire

// file: rtl/lcm_map.vh
`ifndef LCM_MAP_VH
`define LCM_MAP_VH

// register offsets on the serial port
`define LCM_OFS_MASK       8'h20
`define LCM_OFS_SEL        8'h21
`define LCM_OFS_RES_HI     8'h22
`define LCM_OFS_RES_LO     8'h23

// reset values, and the value read at unmapped offsets
`define LCM_MASK_RESET     8'h11
`define LCM_SEL_RESET      8'h00
`define LCM_RES_RESET      10'h000
`define LCM_RD_UNMAPPED    8'h00

// field positions
`define LCM_P2_MASK_BIT    0
`define LCM_P3_MASK_BIT    4
`define LCM_SEL_MSB        1
`define LCM_SEL_LSB        0
`define LCM_RES_HI_MSB     9
`define LCM_RES_HI_LSB     8
`define LCM_RES_LO_MSB     7
`define LCM_RES_LO_LSB     0

// result scale, milliamps per code step
`define LCM_LSB_MA         20

// serial device address, value is arbitrary
`define LCM_DEV_ADDR       7'h60

// measurement time and its cycle count at the 25 ns clock
`define LCM_CLK_PERIOD_NS  25
`define LCM_MEAS_TIME_NS   10000
`define LCM_MEAS_CYCLES    ((`LCM_MEAS_TIME_NS + `LCM_CLK_PERIOD_NS - 1) / `LCM_CLK_PERIOD_NS)

`endif

// file: rtl/lcm_limit_event.v
`timescale 1ns/100ps
`default_nettype none
`include "lcm_map.vh"

module lcm_limit_event
(
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  input  wire limit_in,
  input  wire mask,
  output reg  raw_reg,
  output reg  irq_reg
);

  // raw copy of the live limit, event on its rising edge
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      raw_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else if (ce)
    begin
      raw_reg <= limit_in;
      irq_reg <= limit_in & ~raw_reg & ~mask; // mask blocks event only
    end
  end

endmodule // lcm_limit_event
`default_nettype wire

// file: rtl/lcm_meas_engine.v
`timescale 1ns/100ps
`default_nettype none
`include "lcm_map.vh"

module lcm_meas_engine
#(
  parameter integer MEAS_CYCLES = `LCM_MEAS_CYCLES
)
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        start,
  input  wire [1:0]  phase,
  input  wire [39:0] phase_current_code,
  input  wire [3:0]  phase_is_master,
  input  wire [7:0]  phase_leader,
  output reg  [9:0]  result_reg,
  output reg         done_reg,
  output reg         busy_reg
);

  reg  [15:0] cnt_reg;
  reg  [1:0]  phase_reg;
  reg  [11:0] sum;
  reg  [9:0]  sat;
  integer     i;

  // own current, or master plus all non-master phases led by it
  always @*
  begin
    sum = 12'h000;
    for (i = 0; i < 4; i = i + 1)
    begin
      if (i[1:0] == phase_reg)
        sum = sum + {2'b00, phase_current_code[i*10 +: 10]};
      else if (phase_is_master[phase_reg] && !phase_is_master[i] &&
               phase_leader[i*2 +: 2] == phase_reg)
        sum = sum + {2'b00, phase_current_code[i*10 +: 10]};
    end
    sat = (sum[11:10] != 2'b00) ? 10'h3ff : sum[9:0];
  end

  // a start always restarts, even while busy
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg    <= 16'h0000;
      phase_reg  <= 2'b00;
      result_reg <= `LCM_RES_RESET;
      done_reg   <= 1'b0;
      busy_reg   <= 1'b0;
    end
    else if (ce)
    begin
      done_reg <= 1'b0;
      if (start)
      begin
        phase_reg <= phase;
        cnt_reg   <= MEAS_CYCLES[15:0] - 16'h0001;
        busy_reg  <= 1'b1;
      end
      else if (busy_reg)
      begin
        if (cnt_reg == 16'h0000)
        begin
          result_reg <= sat;                     // whole word at once
          done_reg   <= 1'b1;
          busy_reg   <= 1'b0;
        end
        else
          cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

endmodule // lcm_meas_engine
`default_nettype wire

// file: dv/lcm_load_current_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module lcm_load_current_regs_checker
#(
  parameter integer MEAS_CYCLES = 400
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic phase2_limit_in,
  input wire logic phase3_limit_in,
  input wire logic meas_ready_mask,
  input wire logic phase2_overcurrent_raw,
  input wire logic phase3_overcurrent_raw,
  input wire logic phase2_overcurrent_irq,
  input wire logic phase3_overcurrent_irq,
  input wire logic meas_ready_irq,
  input wire logic meas_busy
);
  localparam int BMAX = MEAS_CYCLES + 4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // raw bits follow the live limit whatever the mask
  AST_RAW2:
    assert property (ce |=> phase2_overcurrent_raw == $past(phase2_limit_in))
    else $error("phase two raw bit does not follow limit");
  AST_RAW3:
    assert property (ce |=> phase3_overcurrent_raw == $past(phase3_limit_in))
    else $error("phase three raw bit does not follow limit");
  // events are single pulses caused by an active limit
  AST_IRQ2_PULSE:
    assert property (phase2_overcurrent_irq && ce |=> !phase2_overcurrent_irq)
    else $error("phase two event longer than one cycle");
  AST_IRQ3_PULSE:
    assert property (phase3_overcurrent_irq && ce |=> !phase3_overcurrent_irq)
    else $error("phase three event longer than one cycle");
  AST_IRQ2_CAUSE:
    assert property (phase2_overcurrent_irq |-> phase2_overcurrent_raw)
    else $error("phase two event without active limit");
  AST_IRQ3_CAUSE:
    assert property (phase3_overcurrent_irq |-> phase3_overcurrent_raw)
    else $error("phase three event without active limit");
  // ready event follows the end of a measurement unless masked
  AST_RDY_PULSE:
    assert property (meas_ready_irq && ce |=> !meas_ready_irq)
    else $error("ready event longer than one cycle");
  AST_RDY_MASK:
    assert property (meas_ready_irq |-> !$past(meas_ready_mask))
    else $error("ready event while masked");
  AST_RDY_AFTER:
    assert property ($fell(meas_busy) && !meas_ready_mask |-> ##[0:2]
      meas_ready_irq)
    else $error("no ready event after measurement");
  AST_BUSY_LEN:
    assert property ($rose(meas_busy) |-> ##[1:BMAX] !meas_busy)
    else $error("measurement runs too long");
  // open-drain data pin: pulls low only, changes only while clock is low
  AST_SDA_OD:
    assert property (!sda_out)
    else $error("data pin driven high");
  AST_SDA_HOLD:
    assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("data pin changed while serial clock high");
  COV_IRQ2: cover property (phase2_overcurrent_irq);
  COV_IRQ3: cover property (phase3_overcurrent_irq);
  COV_RDY: cover property (meas_ready_irq);
endmodule // lcm_load_current_regs_checker

bind lcm_load_current_regs lcm_load_current_regs_checker
  #(.MEAS_CYCLES(MEAS_CYCLES)) u_lcm_load_current_regs_checker (
  .clk, .rst_n, .ce, .scl_in, .sda_out, .sda_oe,
  .phase2_limit_in, .phase3_limit_in, .meas_ready_mask,
  .phase2_overcurrent_raw, .phase3_overcurrent_raw, .phase2_overcurrent_irq,
  .phase3_overcurrent_irq, .meas_ready_irq, .meas_busy);
`default_nettype wire

// file: dv/lcm_load_current_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcm_map.vh"
module lcm_load_current_regs_tb;
  localparam integer MC = 4;
  // select, master bits, leader map, expected result
  localparam logic [143:0] ROWS = {
    {2'h0, 4'h1, 8'h00, 10'h3ff}, {2'h1, 4'h1, 8'h00, 10'h045},
    {2'h2, 4'h5, 8'h80, 10'h2f6}, {2'h3, 4'h5, 8'h80, 10'h0f0},
    {2'h0, 4'h5, 8'h80, 10'h168}, {2'h2, 4'h0, 8'h00, 10'h206}};
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         ce = 1'b1;
  reg         scl = 1'b1;
  reg         sda_m = 1'b1;
  reg         lim2 = 1'b0;
  reg         lim3 = 1'b0;
  reg         rdy_mask = 1'b0;
  reg  [39:0] codes = {10'h0f0, 10'h206, 10'h045, 10'h123};
  reg  [3:0]  master = 4'h0;
  reg  [7:0]  leader = 8'h00;
  reg  [7:0]  rd;
  reg  [23:0] row;
  wire        sda_out, sda_oe, raw2, raw3, irq2, irq3, rdy, busy;
  wire        sda_w = sda_m & ~sda_oe; // wired-and data line
  integer     num_errors = 0, compares = 0, cyc = 0, i;
  integer     n_rdy = 0, n_i2 = 0, n_i3 = 0;

  lcm_load_current_regs #(.MEAS_CYCLES(MC)) u_lcm_load_current_regs (
    .clk(clk), .rst_n(rst_n), .ce(ce), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .phase2_limit_in(lim2),
    .phase3_limit_in(lim3), .meas_ready_mask(rdy_mask),
    .phase_current_code(codes), .phase_is_master(master),
    .phase_leader(leader), .phase2_overcurrent_raw(raw2),
    .phase3_overcurrent_raw(raw3), .phase2_overcurrent_irq(irq2),
    .phase3_overcurrent_irq(irq3), .meas_ready_irq(rdy), .meas_busy(busy));

  always #12.5 clk = ~clk;
  // event counters and run limit
  always @(posedge clk)
  begin
    n_rdy <= n_rdy + (rdy === 1'b1);
    n_i2 <= n_i2 + (irq2 === 1'b1);
    n_i3 <= n_i3 + (irq3 === 1'b1);
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      num_errors = num_errors + 1;
      test_done;
    end
  end

  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // start is cond(1,0), stop is cond(0,1)
  task cond(input logic first, input logic second);
    begin
      scl <= 1'b0;
      tick(2);
      sda_m <= first;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_m <= second;
      tick(4);
    end
  endtask
  task xbit(input logic b, output logic r);
    begin
      scl <= 1'b0;
      tick(2);
      sda_m <= b;
      tick(2);
      scl <= 1'b1;
      tick(2);
      r = sda_w;
      tick(2);
    end
  endtask
  // eight bits msb first, then the acknowledge slot
  task xbyte(input logic [7:0] d, output logic [7:0] r);
    integer k;
    logic   a;
    begin
      for (k = 7; k >= 0; k = k - 1)
        xbit(d[k], r[k]);
      xbit(1'b1, a);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    begin
      cond(1'b1, 1'b0);
      xbyte({`LCM_DEV_ADDR, 1'b0}, r);
      xbyte(a, r);
      xbyte(d, r);
      cond(1'b0, 1'b1);
    end
  endtask
  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    begin
      cond(1'b1, 1'b0);
      xbyte({`LCM_DEV_ADDR, 1'b0}, d);
      xbyte(a, d);
      cond(1'b1, 1'b0);
      xbyte({`LCM_DEV_ADDR, 1'b1}, d);
      xbyte(8'hff, d);
      cond(1'b0, 1'b1);
    end
  endtask
  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    begin
      rd_reg(a, rd);
      cmp8(rd, exp);
    end
  endtask
  task wait_idle;
    repeat (64) if (busy !== 1'b0) tick(1);
  endtask
  // raise then drop both limits, check raw bits and event counts
  task lim_pulse(input logic [7:0] exp_cnt);
    begin
      lim2 <= 1'b1;
      lim3 <= 1'b1;
      tick(4);
      cmp8({6'h0, raw3, raw2}, 8'h03);
      lim2 <= 1'b0;
      lim3 <= 1'b0;
      tick(4);
      cmp8({6'h0, raw3, raw2}, 8'h00);
      cmp8({n_i3[3:0], n_i2[3:0]}, exp_cnt);
    end
  endtask
  task test_done;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // main sequence
  initial
  begin
    tick(20);
    rst_n <= 1'b1;
    tick(2);
    for (i = 0; i < 6; i = i + 1)
    begin
      row = ROWS[(5 - i) * 24 +: 24];
      master <= row[21:18];
      leader <= row[17:10];
      wr_reg(`LCM_OFS_SEL, {6'h0, row[23:22]});
      wait_idle;
      rdchk(`LCM_OFS_SEL, {6'h0, row[23:22]});
      rdchk(`LCM_OFS_RES_HI, {6'h0, row[9:8]});
      rdchk(`LCM_OFS_RES_LO, row[7:0]);
    end
    cmp8(n_rdy[7:0], 8'h06);
    $display("test measure rows done");
    codes <= {10'h0f0, 10'h0aa, 10'h045, 10'h123};
    tick(4);
    rdchk(`LCM_OFS_RES_LO, 8'h06);
    wr_reg(`LCM_OFS_SEL, 8'h02);
    wait_idle;
    rdchk(`LCM_OFS_RES_LO, 8'haa);
    rdchk(`LCM_OFS_RES_HI, 8'h00);
    wr_reg(`LCM_OFS_RES_LO, 8'h55);
    rdchk(`LCM_OFS_RES_LO, 8'haa);
    rdy_mask <= 1'b1;
    wr_reg(`LCM_OFS_SEL, 8'h01);
    wait_idle;
    tick(4);
    cmp8(n_rdy[7:0], 8'h07);
    rdy_mask <= 1'b0;
    $display("test retrigger and hold done");
    lim_pulse(8'h00);
    wr_reg(`LCM_OFS_MASK, 8'h10);
    lim_pulse(8'h01);
    wr_reg(`LCM_OFS_MASK, 8'h01);
    lim_pulse(8'h11);
    wr_reg(`LCM_OFS_MASK, 8'hee);
    lim_pulse(8'h22);
    rdchk(`LCM_OFS_MASK, 8'hee);
    // clock enable low freezes the raw bit and the event
    ce <= 1'b0;
    lim2 <= 1'b1;
    tick(4);
    cmp8({7'h0, raw2}, 8'h00);
    ce <= 1'b1;
    tick(4);
    cmp8({7'h0, raw2}, 8'h01);
    cmp8({n_i3[3:0], n_i2[3:0]}, 8'h23);
    lim2 <= 1'b0;
    $display("test overcurrent masks done");
    rst_n <= 1'b0;
    tick(20);
    rst_n <= 1'b1;
    tick(2);
    rdchk(`LCM_OFS_MASK, `LCM_MASK_RESET);
    rdchk(`LCM_OFS_SEL, `LCM_SEL_RESET);
    rdchk(`LCM_OFS_RES_HI, 8'h00);
    rdchk(`LCM_OFS_RES_LO, 8'h00);
    rdchk(8'h30, `LCM_RD_UNMAPPED);
    $display("test reset values done");
    test_done;
  end
endmodule // lcm_load_current_regs_tb
`default_nettype wire
